// *** plc_pkg.sv ***
/*
  Shared constants and types of the parallel I/O line controller: register
  byte addresses, field layouts, reset values and the AXI4-Lite answer codes.
  Assumes a 32-bit AXI4-Lite register bus and 32 I/O lines.
*/
package plc_pkg;

  localparam int LINES = 32;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;

  // Register byte addresses.
  localparam logic [31:0] ADDR_DRIVEN_LEVEL = 32'h400E_0E38;
  localparam logic [31:0] ADDR_PIN_LEVEL = 32'h400E_0E3C;
  localparam logic [31:0] ADDR_IRQ_ENABLE = 32'h400E_0E40;
  localparam logic [31:0] ADDR_IRQ_DISABLE = 32'h400E_0E44;
  localparam logic [31:0] ADDR_IRQ_MASK = 32'h400E_0E48;
  localparam logic [31:0] ADDR_IRQ_STATUS = 32'h400E_0E4C;
  localparam logic [31:0] ADDR_OD_ENABLE = 32'h400E_0E50;
  localparam logic [31:0] ADDR_OD_DISABLE = 32'h400E_0E54;
  localparam logic [31:0] ADDR_OD_STATE = 32'h400E_0E58;
  localparam logic [31:0] ADDR_PU_DISABLE = 32'h400E_0E60;
  localparam logic [31:0] ADDR_PU_ENABLE = 32'h400E_0E64;
  localparam logic [31:0] ADDR_PU_STATE = 32'h400E_0E68;
  localparam logic [31:0] ADDR_FSEL_LOW = 32'h400E_0E70;
  localparam logic [31:0] ADDR_FSEL_HIGH = 32'h400E_0E74;
  localparam logic [31:0] ADDR_GLITCH_SEL = 32'h400E_0E80;
  localparam logic [31:0] ADDR_DEBOUNCE_SEL = 32'h400E_0E84;
  localparam logic [31:0] ADDR_FILTER_STATE = 32'h400E_0E88;
  localparam logic [31:0] ADDR_PRESCALE = 32'h400E_0E8C;
  localparam logic [31:0] ADDR_WPROT = 32'h400E_0EE4;

  // Field layouts.
  localparam int DIV_W = 14;
  localparam int WPROT_BIT = 0;

  // Reset values.
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] RST_PU_OFF = 32'h0000_0000;
  localparam logic [DIV_W-1:0] RST_DIV = 14'h0000;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Per-line peripheral function, coded as (high select, low select).
  typedef enum logic [1:0] {
    PLC_FUNC_A = 2'b00,
    PLC_FUNC_B = 2'b01,
    PLC_FUNC_C = 2'b10,
    PLC_FUNC_D = 2'b11
  } plc_func_t;

  // Line configuration that travels together.
  typedef struct packed {
    logic [LINES-1:0] irq_mask;
    logic [LINES-1:0] open_drain;
    logic [LINES-1:0] pullup_on;
    logic [LINES-1:0] fsel_low;
    logic [LINES-1:0] fsel_high;
    logic [LINES-1:0] debounce;
  } plc_cfg_t;

endpackage

// *** plc_line_ctrl.sv ***
/*
  Parallel I/O line controller: per-line driven level, pin sampling with a
  glitch filter or slow-clock debouncer, input-change interrupts, open-drain
  and pull-up control, four-way function selection, behind AXI4-Lite.
  Assumes pads and SLCK_I are asynchronous to CLK_I and that SLCK_I is much
  slower than CLK_I; the pad wire level is resolved outside from PAD_OE_N_O.
*/
// Overview of operation
// - Driven level register reports the level driven on each line.
// - Pin level register returns the actual sampled level of each line.
// - Writing one to interrupt enable turns on that line's change interrupt.
// - Writing one to interrupt disable turns off that line's change interrupt.
// - Interrupt mask reads one for every line with change interrupt enabled.
// - Status bit sets on a detected input change; reading status clears it.
// - Writing one to open-drain enable switches that line to open drain.
// - Writing one to open-drain disable returns that line to push-pull.
// - Open-drain lines drive only low; push-pull lines drive both levels.
// - Write protection blocks open-drain, pull-up and function select writes.
// - Writing one to pull-up disable removes that line's pull-up.
// - Writing one to pull-up enable connects that line's pull-up.
// - Pull-up state reads zero when enabled, one when disabled.
// - Function pair (high, low): 00 A, 01 B, 10 C, 11 D.
// - Glitch select uses a peripheral-clock filter rejecting half-period pulses.
// - Debounce select rejects pulses under half the divided slow clock period.
// - Divided slow clock period is slow period times twice (divider plus one).
`timescale 1ns/1ps
module plc_line_ctrl (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic SLCK_I,
  input wire logic [31:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [31:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] PAD_I,
  output logic [31:0] PAD_O,
  output logic [31:0] PAD_OE_N_O,
  output logic [31:0] PULLUP_EN_O,
  output plc_pkg::plc_func_t [31:0] FUNC_SEL_O,
  output logic IRQ_O
);

  plc_pkg::plc_cfg_t cfg_reg;
  logic [31:0] driven_reg;
  logic [31:0] status_reg;
  logic wprot_reg;
  logic [plc_pkg::DIV_W-1:0] div_reg;

  logic [31:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  logic [31:0] pad_meta_reg;
  logic [31:0] pad_sync_reg;
  logic [31:0] pad_prev_reg;
  logic [31:0] filt_reg;
  logic [31:0] filt_prev_reg;
  logic [31:0] deb_sample_reg;
  logic slck_meta_reg;
  logic slck_sync_reg;
  logic slck_prev_reg;
  logic [plc_pkg::DIV_W-1:0] slck_cnt_reg;
  logic half_tick_reg;

  logic wr_fire;
  logic rd_fire;
  logic [31:0] wmask;
  logic [31:0] wbits;
  logic wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [31:0] change;

  // Write mask from the strobes: eight set bits per written byte lane.
  assign wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
  assign wbits = wdata_reg & wmask;
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign rd_fire = S_AXI_ARVALID_I && !rvalid_reg;

  assign S_AXI_AWREADY_O = !aw_held_reg;
  assign S_AXI_WREADY_O = !w_held_reg;
  assign S_AXI_BVALID_O = bvalid_reg;
  assign S_AXI_BRESP_O = bresp_reg;
  assign S_AXI_ARREADY_O = !rvalid_reg;
  assign S_AXI_RVALID_O = rvalid_reg;
  assign S_AXI_RDATA_O = rdata_reg;
  assign S_AXI_RRESP_O = rresp_reg;

  // Address and data are held separately so they may arrive in either order.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= plc_pkg::RST_ZERO;
    end else if (S_AXI_AWVALID_I && !aw_held_reg) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= S_AXI_AWADDR_I;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      w_held_reg <= 1'b0;
      wdata_reg <= plc_pkg::RST_ZERO;
      wstrb_reg <= 4'h0;
    end else if (S_AXI_WVALID_I && !w_held_reg) begin
      w_held_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA_I;
      wstrb_reg <= S_AXI_WSTRB_I;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_comb begin
    if (awaddr_reg == plc_pkg::ADDR_DRIVEN_LEVEL) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_IRQ_ENABLE || awaddr_reg == plc_pkg::ADDR_IRQ_DISABLE) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_OD_ENABLE || awaddr_reg == plc_pkg::ADDR_OD_DISABLE) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_PU_ENABLE || awaddr_reg == plc_pkg::ADDR_PU_DISABLE) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_FSEL_LOW || awaddr_reg == plc_pkg::ADDR_FSEL_HIGH) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_GLITCH_SEL) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_DEBOUNCE_SEL) begin
      wr_hit = 1'b1;
    end else if (awaddr_reg == plc_pkg::ADDR_PRESCALE || awaddr_reg == plc_pkg::ADDR_WPROT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= plc_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      driven_reg <= plc_pkg::RST_ZERO;
      div_reg <= plc_pkg::RST_DIV;
      wprot_reg <= 1'b0;
    end else if (wr_fire) begin
      if (awaddr_reg == plc_pkg::ADDR_DRIVEN_LEVEL) begin
        driven_reg <= (driven_reg & ~wmask) | wbits;
      end else if (awaddr_reg == plc_pkg::ADDR_PRESCALE && wstrb_reg[0] && wstrb_reg[1]) begin
        div_reg <= wdata_reg[plc_pkg::DIV_W-1:0];
      end else if (awaddr_reg == plc_pkg::ADDR_WPROT && wstrb_reg[0]) begin
        wprot_reg <= wdata_reg[plc_pkg::WPROT_BIT];
      end
    end
  end

  // Set and clear registers touch only the lines whose written bit is one.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_reg <= '0;
    end else if (wr_fire) begin
      if (awaddr_reg == plc_pkg::ADDR_IRQ_ENABLE) begin
        cfg_reg.irq_mask <= cfg_reg.irq_mask | wbits;
      end else if (awaddr_reg == plc_pkg::ADDR_IRQ_DISABLE) begin
        cfg_reg.irq_mask <= cfg_reg.irq_mask & ~wbits;
      end else if (awaddr_reg == plc_pkg::ADDR_GLITCH_SEL) begin
        cfg_reg.debounce <= cfg_reg.debounce & ~wbits;
      end else if (awaddr_reg == plc_pkg::ADDR_DEBOUNCE_SEL) begin
        cfg_reg.debounce <= cfg_reg.debounce | wbits;
      end else if (!wprot_reg) begin
        if (awaddr_reg == plc_pkg::ADDR_OD_ENABLE) begin
          cfg_reg.open_drain <= cfg_reg.open_drain | wbits;
        end else if (awaddr_reg == plc_pkg::ADDR_OD_DISABLE) begin
          cfg_reg.open_drain <= cfg_reg.open_drain & ~wbits;
        end else if (awaddr_reg == plc_pkg::ADDR_PU_ENABLE) begin
          cfg_reg.pullup_on <= cfg_reg.pullup_on | wbits;
        end else if (awaddr_reg == plc_pkg::ADDR_PU_DISABLE) begin
          cfg_reg.pullup_on <= cfg_reg.pullup_on & ~wbits;
        end else if (awaddr_reg == plc_pkg::ADDR_FSEL_LOW) begin
          cfg_reg.fsel_low <= (cfg_reg.fsel_low & ~wmask) | wbits;
        end else if (awaddr_reg == plc_pkg::ADDR_FSEL_HIGH) begin
          cfg_reg.fsel_high <= (cfg_reg.fsel_high & ~wmask) | wbits;
        end
      end
    end
  end

  always_comb begin
    rd_hit = 1'b1;
    if (S_AXI_ARADDR_I == plc_pkg::ADDR_DRIVEN_LEVEL) begin
      rd_val = driven_reg;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_PIN_LEVEL) begin
      rd_val = pad_sync_reg;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_IRQ_MASK) begin
      rd_val = cfg_reg.irq_mask;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_IRQ_STATUS) begin
      rd_val = status_reg;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_OD_STATE) begin
      rd_val = cfg_reg.open_drain;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_PU_STATE) begin
      rd_val = ~cfg_reg.pullup_on;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_FSEL_LOW) begin
      rd_val = cfg_reg.fsel_low;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_FSEL_HIGH) begin
      rd_val = cfg_reg.fsel_high;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_FILTER_STATE) begin
      rd_val = cfg_reg.debounce;
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_PRESCALE) begin
      rd_val = {{(32 - plc_pkg::DIV_W){1'b0}}, div_reg};
    end else if (S_AXI_ARADDR_I == plc_pkg::ADDR_WPROT) begin
      rd_val = {31'h0000_0000, wprot_reg};
    end else begin
      rd_val = plc_pkg::RST_ZERO;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= plc_pkg::RST_ZERO;
      rresp_reg <= plc_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= rd_hit ? plc_pkg::RESP_OKAY : plc_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY_I) begin
      rvalid_reg <= 1'b0;
    end
  end

  // A change seen in the same cycle as the clearing read stays set.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      status_reg <= plc_pkg::RST_ZERO;
    end else if (rd_fire && S_AXI_ARADDR_I == plc_pkg::ADDR_IRQ_STATUS) begin
      status_reg <= change;
    end else begin
      status_reg <= status_reg | change;
    end
  end

  assign IRQ_O = |(status_reg & cfg_reg.irq_mask);

  // Pads and the slow clock are foreign to CLK_I: two flops before use.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pad_meta_reg <= plc_pkg::RST_ZERO;
      pad_sync_reg <= plc_pkg::RST_ZERO;
      pad_prev_reg <= plc_pkg::RST_ZERO;
      slck_meta_reg <= 1'b0;
      slck_sync_reg <= 1'b0;
      slck_prev_reg <= 1'b0;
    end else begin
      pad_meta_reg <= PAD_I;
      pad_sync_reg <= pad_meta_reg;
      pad_prev_reg <= pad_sync_reg;
      slck_meta_reg <= SLCK_I;
      slck_sync_reg <= slck_meta_reg;
      slck_prev_reg <= slck_sync_reg;
    end
  end

  // One tick every DIV+1 slow clock rising edges marks each half of the
  // divided period, so the full period is (DIV+1)*2 slow clock periods.
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      slck_cnt_reg <= plc_pkg::RST_DIV;
      half_tick_reg <= 1'b0;
    end else if (slck_sync_reg && !slck_prev_reg) begin
      if (slck_cnt_reg >= div_reg) begin
        slck_cnt_reg <= plc_pkg::RST_DIV;
        half_tick_reg <= 1'b1;
      end else begin
        slck_cnt_reg <= slck_cnt_reg + 1'b1;
        half_tick_reg <= 1'b0;
      end
    end else begin
      half_tick_reg <= 1'b0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < plc_pkg::LINES; g++) begin : g_line
      // The debouncer accepts a level only when two successive half-period
      // samples agree, so shorter pulses never reach the filtered level.
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          deb_sample_reg[g] <= 1'b0;
          filt_reg[g] <= 1'b0;
        end else if (cfg_reg.debounce[g]) begin
          if (half_tick_reg) begin
            deb_sample_reg[g] <= pad_sync_reg[g];
            if (deb_sample_reg[g] == pad_sync_reg[g]) begin
              filt_reg[g] <= pad_sync_reg[g];
            end
          end
        end else begin
          deb_sample_reg[g] <= pad_sync_reg[g];
          if (pad_prev_reg[g] == pad_sync_reg[g]) begin
            filt_reg[g] <= pad_sync_reg[g];
          end
        end
      end

      // Open drain releases the pad for a high level instead of driving it.
      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          PAD_O[g] <= 1'b0;
          PAD_OE_N_O[g] <= 1'b0;
        end else begin
          PAD_O[g] <= driven_reg[g];
          PAD_OE_N_O[g] <= cfg_reg.open_drain[g] & driven_reg[g];
        end
      end

      always_ff @(posedge CLK_I) begin
        if (RST_I) begin
          PULLUP_EN_O[g] <= 1'b0;
          FUNC_SEL_O[g] <= plc_pkg::PLC_FUNC_A;
        end else begin
          PULLUP_EN_O[g] <= cfg_reg.pullup_on[g];
          FUNC_SEL_O[g] <= plc_pkg::plc_func_t'({cfg_reg.fsel_high[g], cfg_reg.fsel_low[g]});
        end
      end
    end
  endgenerate

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      filt_prev_reg <= plc_pkg::RST_ZERO;
    end else begin
      filt_prev_reg <= filt_reg;
    end
  end

  assign change = filt_reg ^ filt_prev_reg;

endmodule

// *** plc_pad_model.sv ***
/*
  Pad model of the line controller: resolves each I/O wire from the
  controller's drive, the bench's external drive and the pull-up.
  Assumes the bench drives ext_i only where ext_en_i is set.
*/
`timescale 1ns/1ps
module plc_pad_model (
  input wire logic clk_i,
  input wire logic [31:0] pad_o_i,
  input wire logic [31:0] oe_n_i,
  input wire logic [31:0] pu_i,
  input wire logic [31:0] ext_i,
  input wire logic [31:0] ext_en_i,
  output logic [31:0] wire_o
);
  logic [31:0] float_reg = 32'h5555_5555;
  // An undriven line without pull-up must not hold a stable value.
  always_ff @(posedge clk_i) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (!oe_n_i[i]) begin
        wire_o[i] = pad_o_i[i];
      end else if (ext_en_i[i]) begin
        wire_o[i] = ext_i[i];
      end else if (pu_i[i]) begin
        wire_o[i] = 1'h1;
      end else begin
        wire_o[i] = float_reg[i];
      end
    end
  end
endmodule

// *** plc_line_ctrl_checker.sv ***
/*
  Checker of the line controller: bus handshake timing, reset state and
  pad drive. Bound to plc_line_ctrl and sees its ports only.
*/
`timescale 1ns/1ps
module plc_line_ctrl_checker (
  input wire logic CLK_I,
  input wire logic RST_I,
  input wire logic S_AXI_AWVALID_I,
  input wire logic S_AXI_AWREADY_O,
  input wire logic S_AXI_WVALID_I,
  input wire logic S_AXI_WREADY_O,
  input wire logic [1:0] S_AXI_BRESP_O,
  input wire logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic S_AXI_ARVALID_I,
  input wire logic S_AXI_ARREADY_O,
  input wire logic [31:0] S_AXI_RDATA_O,
  input wire logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  input wire logic [31:0] PAD_O,
  input wire logic [31:0] PAD_OE_N_O,
  input wire logic [31:0] PULLUP_EN_O,
  input wire logic IRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I);
  property p_bhold;
    S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped early");
  property p_rhold;
    S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped early");
  property p_rlat;
    S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_arrdy;
    S_AXI_RVALID_O |-> !S_AXI_ARREADY_O;
  endproperty
  a_arrdy: assert property (p_arrdy) else $error("read address taken while busy");
  property p_wlat;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
      |-> ##2 S_AXI_BVALID_O;
  endproperty
  a_wlat: assert property (p_wlat) else $error("write answer late");
  // A taken address and data stay held, refusing more, until the write completes.
  property p_wrdy;
    S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O
      |=> !S_AXI_AWREADY_O && !S_AXI_WREADY_O;
  endproperty
  a_wrdy: assert property (p_wrdy) else $error("write taken while busy");
  property p_od;
    (PAD_OE_N_O & ~PAD_O) == 32'h0000_0000;
  endproperty
  a_od: assert property (p_od) else $error("line released while low");
  property p_rst;
    $past(RST_I) |-> !S_AXI_BVALID_O && !S_AXI_RVALID_O && !IRQ_O
      && PAD_O == 32'h0000_0000 && PULLUP_EN_O == 32'h0000_0000;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset state");
endmodule

bind plc_line_ctrl plc_line_ctrl_checker i_plc_line_ctrl_checker (
  .CLK_I(CLK_I), .RST_I(RST_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I),
  .S_AXI_AWREADY_O(S_AXI_AWREADY_O), .S_AXI_WVALID_I(S_AXI_WVALID_I),
  .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
  .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I),
  .S_AXI_ARVALID_I(S_AXI_ARVALID_I), .S_AXI_ARREADY_O(S_AXI_ARREADY_O),
  .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RVALID_O(S_AXI_RVALID_O),
  .S_AXI_RREADY_I(S_AXI_RREADY_I), .PAD_O(PAD_O), .PAD_OE_N_O(PAD_OE_N_O),
  .PULLUP_EN_O(PULLUP_EN_O), .IRQ_O(IRQ_O));

// *** tb_top.sv ***
/*
  Self-checking bench of the line controller: register access over
  AXI4-Lite, pad drive, filtering and change interrupts. Assumes the pad
  model resolves the wires and a free-running 10 MHz slow clock.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  logic clk = 0, rst = 1, slck = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic [3:0] strb = 4'hF;
  logic arvalid = 0, rready = 0, awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] awaddr = 0, wdata = 0, araddr = 0, ext = 0, ext_en = 0;
  logic [31:0] rdata, pad_i, pad_o, oe_n, pu_en, rd_v, a, b, c, oe;
  logic [31:0] m = 0, od = 0, pu = 0;
  logic [1:0] bresp, rresp;
  plc_pkg::plc_func_t [31:0] fsel;
  int error_cnt = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  always #50 slck = ~slck;
  plc_line_ctrl i_plc_line_ctrl (.CLK_I(clk), .RST_I(rst), .SLCK_I(slck),
    .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready),
    .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(strb), .S_AXI_WVALID_I(wvalid),
    .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid),
    .S_AXI_BREADY_I(bready), .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid),
    .S_AXI_ARREADY_O(arready), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
    .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready), .PAD_I(pad_i), .PAD_O(pad_o),
    .PAD_OE_N_O(oe_n), .PULLUP_EN_O(pu_en), .FUNC_SEL_O(fsel), .IRQ_O(irq));
  plc_pad_model i_plc_pad_model (.clk_i(clk), .pad_o_i(pad_o), .oe_n_i(oe_n),
    .pu_i(pu_en), .ext_i(ext), .ext_en_i(ext_en), .wire_o(pad_i));
  function automatic plc_pkg::plc_func_t f_sel(logic h, logic l);
    if (h) return l ? plc_pkg::PLC_FUNC_D : plc_pkg::PLC_FUNC_C;
    return l ? plc_pkg::PLC_FUNC_B : plc_pkg::PLC_FUNC_A;
  endfunction
  task final_report;
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic tmo(inout int n);
    n++;
    if (n > 200) begin
      error_cnt++;
      final_report;
    end
  endtask
  task automatic wr(input logic [31:0] ad, d, input logic [1:0] er = plc_pkg::RESP_OKAY);
    bit pa, pw;
    int n;
    pa = 1;
    pw = 1;
    n = 0;
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    do begin
      @(posedge clk);
      tmo(n);
      if (pa && awready === 1) begin pa = 0; awvalid <= 0; end
      if (pw && wready === 1) begin pw = 0; wvalid <= 0; end
    end while (bvalid !== 1);
    // The answer is taken one cycle late so that the slave must hold it.
    bready <= 1;
    @(posedge clk);
    bready <= 0;
    `CHK(bresp, er)
  endtask
  task automatic rd(input logic [31:0] ad, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1;
    do begin
      @(posedge clk);
      tmo(n);
      if (arready === 1) arvalid <= 0;
    end while (rvalid !== 1);
    rready <= 1;
    @(posedge clk);
    rd_v = rdata;
    rready <= 0;
    `CHK(rresp, er)
  endtask
  task automatic rc(input logic [31:0] ad, e);
    rd(ad, plc_pkg::RESP_OKAY);
    `CHK(rd_v, e)
  endtask
  initial begin
    a = $urandom(34125);
    repeat (6) @(posedge clk);
    rst <= 0;
    rc(plc_pkg::ADDR_PU_STATE, 32'hFFFF_FFFF);
    rc(plc_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    rc(plc_pkg::ADDR_OD_STATE, 32'h0000_0000);
    for (int k = 0; k < 5; k++) begin
      a = $urandom();
      b = (k == 0) ? 32'h0000_0000 : $urandom();
      c = $urandom();
      ext <= $urandom();
      ext_en <= 32'hFFFF_FFFF;
      wr(plc_pkg::ADDR_IRQ_ENABLE, a);
      wr(plc_pkg::ADDR_IRQ_DISABLE, b);
      m = (m | a) & ~b;
      rc(plc_pkg::ADDR_IRQ_MASK, m);
      wr(plc_pkg::ADDR_OD_ENABLE, a);
      wr(plc_pkg::ADDR_OD_DISABLE, b);
      od = (od | a) & ~b;
      rc(plc_pkg::ADDR_OD_STATE, od);
      wr(plc_pkg::ADDR_PU_ENABLE, b);
      wr(plc_pkg::ADDR_PU_DISABLE, a);
      pu = (pu | b) & ~a;
      rc(plc_pkg::ADDR_PU_STATE, ~pu);
      `CHK(pu_en, pu)
      wr(plc_pkg::ADDR_DRIVEN_LEVEL, c);
      rc(plc_pkg::ADDR_DRIVEN_LEVEL, c);
      oe = od & c;
      `CHK(pad_o, c)
      `CHK(oe_n, oe)
      rc(plc_pkg::ADDR_PIN_LEVEL, (oe & ext) | (~oe & c));
      wr(plc_pkg::ADDR_FSEL_LOW, a);
      wr(plc_pkg::ADDR_FSEL_HIGH, b);
      rc(plc_pkg::ADDR_FSEL_LOW, a);
      rc(plc_pkg::ADDR_FSEL_HIGH, b);
      for (int i = 0; i < 32; i++) `CHK(fsel[i], f_sel(b[i], a[i]))
    end
    wr(plc_pkg::ADDR_WPROT, 32'h0000_0001);
    wr(plc_pkg::ADDR_OD_ENABLE, ~od);
    wr(plc_pkg::ADDR_PU_ENABLE, ~pu);
    wr(plc_pkg::ADDR_FSEL_LOW, ~a);
    rc(plc_pkg::ADDR_OD_STATE, od);
    rc(plc_pkg::ADDR_PU_STATE, ~pu);
    rc(plc_pkg::ADDR_FSEL_LOW, a);
    wr(plc_pkg::ADDR_WPROT, 32'h0000_0000);
    // Only byte lane 0 is written, so the upper lines keep their level.
    strb <= 4'h1;
    wr(plc_pkg::ADDR_DRIVEN_LEVEL, 32'h0000_0000);
    strb <= 4'hF;
    rc(plc_pkg::ADDR_DRIVEN_LEVEL, c & 32'hFFFF_FF00);
    rd(32'h400E_0E5C, plc_pkg::RESP_SLVERR);
    `CHK(rd_v, 32'h0000_0000)
    wr(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000, plc_pkg::RESP_SLVERR);
    // Release every line so the bench alone sets the pad levels.
    wr(plc_pkg::ADDR_OD_ENABLE, 32'hFFFF_FFFF);
    wr(plc_pkg::ADDR_DRIVEN_LEVEL, 32'hFFFF_FFFF);
    ext <= 32'h0000_0000;
    wr(plc_pkg::ADDR_IRQ_DISABLE, 32'hFFFF_FFFF);
    wr(plc_pkg::ADDR_IRQ_ENABLE, 32'h0000_0001);
    repeat (20) @(posedge clk);
    rd(plc_pkg::ADDR_IRQ_STATUS, plc_pkg::RESP_OKAY);
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    ext[0] <= 1;
    repeat (10) @(posedge clk);
    `CHK(irq, 1'h1)
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    `CHK(irq, 1'h0)
    wr(plc_pkg::ADDR_IRQ_DISABLE, 32'h0000_0001);
    ext[0] <= 0;
    repeat (10) @(posedge clk);
    `CHK(irq, 1'h0)
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0001);
    ext[1] <= 1;
    @(posedge clk);
    ext[1] <= 0;
    repeat (10) @(posedge clk);
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    // Samples every 400 ns, so a 300 ns pulse meets at most one sample.
    wr(plc_pkg::ADDR_PRESCALE, 32'h0000_0003);
    wr(plc_pkg::ADDR_DEBOUNCE_SEL, 32'h0000_0004);
    rc(plc_pkg::ADDR_FILTER_STATE, 32'h0000_0004);
    ext[2] <= 1;
    repeat (60) @(posedge clk);
    ext[2] <= 0;
    repeat (900) @(posedge clk);
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    ext[2] <= 1;
    repeat (900) @(posedge clk);
    rc(plc_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
    wr(plc_pkg::ADDR_GLITCH_SEL, 32'h0000_0004);
    rc(plc_pkg::ADDR_FILTER_STATE, 32'h0000_0000);
    final_report;
  end
endmodule
